/* File: rtl/pbt_input.sv */
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps
`include "pbt_defines.svh"
// Overview of operation
// - start/stop dimming: direction on press, stop on release
// - 4-bit dim code, top bit means brighter
// - stepped dimming repeats while long press lasts
// - stepped dimming carries configured step size
// - dimming repeat period configurable, 0.6 s default
// - react at once, ignore edges in debounce window
// - contact type selects actuated level
// - internal link drives blind output commands
// - one button: short step, long move
// - one button: short move, long repeated step
// - one button cycles up, stop, down, stop
// - one switch: move on press, stop on release
// - two button: short slat, long move
// - two switch: move on press, slat on release
// - move-only or slat-only per actuation
// - last direction follows object and limit positions
// - long press after configurable threshold
// - slat repeat period configurable, 0.5 s default
// - block ignores input, cyclic sending continues
// - value mode decides short/long before sending
// - edges restart minimum timer, send on expiry
module pbt_input
   import pbt_pkg::*;
#(
   parameter int TICK_CYC = `PBT_TICK_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        contact_in,
   input  wire logic        updown_obj_wr,
   input  wire logic        updown_obj_val,
   output logic             dim_send,
   output logic      [3:0]  dim_code,
   output logic             move_send,
   output logic             move_down,
   output logic             slat_send,
   output logic             slat_close,
   output logic             val_short_send,
   output logic             val_long_send,
   output logic      [3:0]  link_move_send,
   output logic      [3:0]  link_slat_send,
   output logic             link_dir
);
   logic [1:0]  rst_sync_q;
   logic        rst_ok;
   logic [1:0]  pin_q;
   logic [31:0] ctrl_q;
   logic [15:0] deb_q, long_q, cyc_q, slat_q, min_q;
   logic [14:0] tick_cnt_q;
   logic        tick;
   logic        act_q, act_prev_q;
   logic [15:0] deb_cnt_q;
   logic [15:0] tmr_q;
   logic [22:0] min_cnt_q;
   pbt_state_e  st_q;
   logic        last_down_q;
   logic [1:0]  cyc_ph_q;
   logic [15:0] resend_cnt_q;
   logic        resend;
   logic        ev_move, ev_slat, ev_dim, ev_vs, ev_vl;
   logic        ev_move_dn, ev_slat_cl;
   logic [3:0]  ev_code;
   logic        raw_act, press, release_e;
   pbt_mode_e   mode;
   pbt_blind_e  bmode;
   logic        cfg_dir;

   assign mode    = pbt_mode_e'(ctrl_q[`PBT_CTRL_MODE_LSB +: 2]);
   assign bmode   = pbt_blind_e'(ctrl_q[`PBT_CTRL_BLIND_LSB +: 3]);
   assign cfg_dir = ctrl_q[`PBT_CTRL_DIR_BIT];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) rst_sync_q <= 2'b00;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_ok = rst_sync_q[1];

   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) pin_q <= 2'b00;
      else pin_q <= {pin_q[0], contact_in};
   end

   // common millisecond tick
   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) tick_cnt_q <= 15'h0000;
      else if (tick) tick_cnt_q <= 15'h0000;
      else tick_cnt_q <= tick_cnt_q + 15'h0001;
   end
   assign tick = (tick_cnt_q == 15'(TICK_CYC - 1));

   // apb slave, zero wait state
   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) begin
         ctrl_q <= 32'h0000_0000;
         deb_q  <= `PBT_DEB_MS_RST;
         long_q <= `PBT_LONG_MS_RST;
         cyc_q  <= `PBT_CYC_MS_RST;
         slat_q <= `PBT_SLAT_MS_RST;
         min_q  <= `PBT_MIN_RST;
      end else if (psel && penable && pwrite) begin
         case (paddr)
            `PBT_ADDR_CTRL:   ctrl_q <= pwdata;
            `PBT_ADDR_DEB:    deb_q  <= pwdata[15:0];
            `PBT_ADDR_LONG:   long_q <= pwdata[15:0];
            `PBT_ADDR_CYCLE:  cyc_q  <= pwdata[15:0];
            `PBT_ADDR_SLAT:   slat_q <= pwdata[15:0];
            `PBT_ADDR_MINSIG: min_q  <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               `PBT_ADDR_CTRL:   prdata <= ctrl_q;
               `PBT_ADDR_DEB:    prdata <= {16'h0000, deb_q};
               `PBT_ADDR_LONG:   prdata <= {16'h0000, long_q};
               `PBT_ADDR_CYCLE:  prdata <= {16'h0000, cyc_q};
               `PBT_ADDR_SLAT:   prdata <= {16'h0000, slat_q};
               `PBT_ADDR_MINSIG: prdata <= {16'h0000, min_q};
               `PBT_ADDR_STATUS: prdata <= {26'h000_0000, cyc_ph_q, last_down_q,
                                            st_q, act_q};
               default: begin
                  prdata  <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // contact level, xor with normally-closed selection
   assign raw_act = pin_q[1] ^ ctrl_q[`PBT_CTRL_NC_BIT];

   // first edge taken at once, then window blocks further edges
   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) begin
         act_q     <= 1'b0;
         deb_cnt_q <= 16'h0000;
      end else if (ctrl_q[`PBT_CTRL_BLOCK]) begin
         deb_cnt_q <= 16'h0000;
      end else if (deb_cnt_q != 16'h0000) begin
         if (tick) deb_cnt_q <= deb_cnt_q - 16'h0001;
      end else if (raw_act != act_q) begin
         act_q     <= raw_act;
         deb_cnt_q <= deb_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) act_prev_q <= 1'b0;
      else act_prev_q <= act_q;
   end
   assign press     = act_q && !act_prev_q;
   assign release_e = !act_q && act_prev_q;

   // press timing, repeat and minimum-signal sequencing
   always_comb begin
      ev_move = 1'b0;
      ev_slat = 1'b0;
      ev_dim  = 1'b0;
      ev_vs   = 1'b0;
      ev_vl   = 1'b0;
      ev_move_dn = cfg_dir;
      ev_slat_cl = ctrl_q[`PBT_CTRL_SLATCL];
      ev_code = 4'h0;
      case (mode)
         PBT_MODE_DIM: begin
            if (!ctrl_q[`PBT_CTRL_DSTEP]) begin
               ev_dim  = press || release_e;
               ev_code = press ? {!cfg_dir, 3'b001} : {!cfg_dir, 3'b000};
            end else begin
               ev_dim  = (st_q == PBT_LONG) && (tmr_q == 16'h0000) && tick;
               ev_code = {!cfg_dir, ctrl_q[`PBT_CTRL_STEP_LSB +: 3]};
            end
         end
         PBT_MODE_BLIND: begin
            case (bmode)
               PBT_B1_STEP_MOVE: begin
                  ev_slat    = release_e && st_q == PBT_PRESS;
                  ev_slat_cl = !last_down_q;
                  ev_move    = st_q == PBT_PRESS && tick && tmr_q == long_q;
                  ev_move_dn = !last_down_q;
               end
               PBT_B1_MOVE_STEP: begin
                  ev_move    = release_e && st_q == PBT_PRESS;
                  ev_move_dn = !last_down_q;
                  ev_slat    = (st_q == PBT_LONG) && (tmr_q == 16'h0000) && tick;
                  ev_slat_cl = !last_down_q;
               end
               PBT_B1_CYCLE: begin
                  ev_move    = press && !cyc_ph_q[0];
                  ev_move_dn = cyc_ph_q[1];
                  ev_slat    = press && cyc_ph_q[0];
                  ev_slat_cl = !last_down_q;
               end
               PBT_B1_SWITCH: begin
                  ev_move    = press;
                  ev_move_dn = !last_down_q;
                  ev_slat    = release_e;
                  ev_slat_cl = !last_down_q;
               end
               PBT_B2_STEP_MOVE: begin
                  ev_slat = release_e && st_q == PBT_PRESS;
                  ev_move = st_q == PBT_PRESS && tick && tmr_q == long_q;
               end
               PBT_B2_SWITCH: begin
                  ev_move = press;
                  ev_slat = release_e;
               end
               PBT_B2_MOVE:  ev_move = press;
               PBT_B2_SLAT:  ev_slat = press;
               default: ;
            endcase
         end
         PBT_MODE_VALUE: begin
            if (ctrl_q[`PBT_CTRL_SLD]) begin
               ev_vs = release_e && st_q == PBT_PRESS;
               ev_vl = st_q == PBT_PRESS && tick && tmr_q == long_q;
            end else if (ctrl_q[`PBT_CTRL_MINEN]) begin
               ev_vs = st_q == PBT_WAITMIN && tick && min_cnt_q == 23'h00_0001 && act_q;
               ev_vl = st_q == PBT_WAITMIN && tick && min_cnt_q == 23'h00_0001 && !act_q;
            end else begin
               ev_vs = press;
               ev_vl = release_e;
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) begin
         st_q      <= PBT_IDLE;
         tmr_q     <= 16'h0000;
         min_cnt_q <= 23'h00_0000;
      end else if (mode == PBT_MODE_VALUE && !ctrl_q[`PBT_CTRL_SLD]
                   && ctrl_q[`PBT_CTRL_MINEN]) begin
         if (press || release_e) begin
            st_q      <= PBT_WAITMIN;
            min_cnt_q <= 23'(min_q * `PBT_MIN_UNIT_MS);
         end else if (st_q == PBT_WAITMIN && tick) begin
            min_cnt_q <= min_cnt_q - 23'h00_0001;
            if (min_cnt_q == 23'h00_0001) st_q <= PBT_IDLE;
         end
      end else if (release_e || !act_q) begin
         st_q  <= PBT_IDLE;
         tmr_q <= 16'h0000;
      end else if (press) begin
         st_q  <= PBT_PRESS;
         tmr_q <= 16'h0000;
      end else if (tick) begin
         case (st_q)
            PBT_PRESS: begin
               if (tmr_q == long_q) begin
                  st_q  <= PBT_LONG;
                  tmr_q <= 16'h0000;
               end else tmr_q <= tmr_q + 16'h0001;
            end
            PBT_LONG: begin
               if (tmr_q == 16'h0000) begin
                  tmr_q <= (mode == PBT_MODE_DIM) ? cyc_q - 16'h0001
                                                  : slat_q - 16'h0001;
               end else tmr_q <= tmr_q - 16'h0001;
            end
            default: ;
         endcase
      end
   end

   // remembered direction and one-button cycle phase
   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) begin
         last_down_q <= 1'b0;
         cyc_ph_q    <= 2'b00;
      end else begin
         if (ctrl_q[`PBT_CTRL_UPPER]) last_down_q <= 1'b0;
         else if (ctrl_q[`PBT_CTRL_LOWER]) last_down_q <= 1'b1;
         else if (updown_obj_wr) last_down_q <= updown_obj_val;
         else if (ev_move) last_down_q <= ev_move_dn;
         if (mode == PBT_MODE_BLIND && bmode == PBT_B1_CYCLE && press)
            cyc_ph_q <= cyc_ph_q + 2'b01;
      end
   end

   // while blocked the last state is repeated at the dimming cycle period
   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) resend_cnt_q <= 16'h0000;
      else if (!(ctrl_q[`PBT_CTRL_BLOCK] && ctrl_q[`PBT_CTRL_CYCSEND]))
         resend_cnt_q <= cyc_q - 16'h0001;
      else if (tick) begin
         if (resend_cnt_q == 16'h0000) resend_cnt_q <= cyc_q - 16'h0001;
         else resend_cnt_q <= resend_cnt_q - 16'h0001;
      end
   end
   assign resend = ctrl_q[`PBT_CTRL_BLOCK] && ctrl_q[`PBT_CTRL_CYCSEND] && tick
                   && resend_cnt_q == 16'h0000;

   // registered outputs; cyclic re-send while blocked
   always_ff @(posedge clk_sys or negedge rst_ok) begin
      if (!rst_ok) begin
         dim_send <= 1'b0;
         dim_code <= 4'h0;
         move_send <= 1'b0;
         move_down <= 1'b0;
         slat_send <= 1'b0;
         slat_close <= 1'b0;
         val_short_send <= 1'b0;
         val_long_send <= 1'b0;
         link_move_send <= 4'h0;
         link_slat_send <= 4'h0;
         link_dir <= 1'b0;
      end else begin
         dim_send  <= ev_dim;
         move_send <= ev_move;
         slat_send <= ev_slat;
         val_short_send <= ev_vs;
         val_long_send  <= ev_vl;
         if (ev_dim) dim_code <= ev_code;
         if (ev_move) move_down <= ev_move_dn;
         if (ev_slat) slat_close <= ev_slat_cl;
         if (resend) begin
            case (mode)
               PBT_MODE_DIM:   dim_send  <= 1'b1;
               PBT_MODE_BLIND: move_send <= 1'b1;
               PBT_MODE_VALUE: begin
                  if (act_q) val_short_send <= 1'b1;
                  else val_long_send <= 1'b1;
               end
               default: ;
            endcase
         end
         link_dir <= ev_move ? ev_move_dn : ev_slat_cl;
         for (int i = 0; i < 4; i++) begin
            link_move_send[i] <= ev_move && ctrl_q[`PBT_CTRL_LINK_LSB +: 3] == 3'(i + 1);
            link_slat_send[i] <= ev_slat && ctrl_q[`PBT_CTRL_LINK_LSB +: 3] == 3'(i + 1);
         end
      end
   end
endmodule

/* File: rtl/pbt_defines.svh */
`ifndef PBT_DEFINES_SVH
`define PBT_DEFINES_SVH
// apb register byte offsets
`define PBT_ADDR_CTRL     12'h000
`define PBT_ADDR_DEB      12'h004
`define PBT_ADDR_LONG     12'h008
`define PBT_ADDR_CYCLE    12'h00C
`define PBT_ADDR_SLAT     12'h010
`define PBT_ADDR_MINSIG   12'h014
`define PBT_ADDR_STATUS   12'h018
// ctrl fields
`define PBT_CTRL_MODE_LSB 0
`define PBT_CTRL_NC_BIT   2
`define PBT_CTRL_DSTEP    3
`define PBT_CTRL_DIR_BIT  4
`define PBT_CTRL_BLIND_LSB 5
`define PBT_CTRL_STEP_LSB 8
`define PBT_CTRL_SLATCL   11
`define PBT_CTRL_LINK_LSB 12
`define PBT_CTRL_SLD      15
`define PBT_CTRL_MINEN    16
`define PBT_CTRL_BLOCK    17
`define PBT_CTRL_CYCSEND  18
`define PBT_CTRL_UPPER    19
`define PBT_CTRL_LOWER    20
// timing (ms / 0.1 s units)
`define PBT_CLK_HZ        25000000
`define PBT_TICK_CYC      (`PBT_CLK_HZ / 1000)
`define PBT_DEB_MS_RST    16'h0032
`define PBT_LONG_MS_RST   16'h0258
`define PBT_CYC_MS_RST    16'h0258
`define PBT_SLAT_MS_RST   16'h01F4
`define PBT_MIN_RST       16'h000A
`define PBT_MIN_UNIT_MS   100
`define PBT_DIM_STOP_UP   4'h8
`endif

/* File: rtl/pbt_pkg.sv */
package pbt_pkg;
   typedef enum logic [1:0] {PBT_MODE_DIM = 2'b00, PBT_MODE_BLIND = 2'b01,
                             PBT_MODE_VALUE = 2'b11} pbt_mode_e;
   typedef enum logic [2:0] {
      PBT_B1_STEP_MOVE = 3'd0, PBT_B1_MOVE_STEP = 3'd1, PBT_B1_CYCLE = 3'd2,
      PBT_B1_SWITCH = 3'd3, PBT_B2_STEP_MOVE = 3'd4, PBT_B2_SWITCH = 3'd5,
      PBT_B2_MOVE = 3'd6, PBT_B2_SLAT = 3'd7} pbt_blind_e;
   typedef enum logic [1:0] {PBT_IDLE = 2'b00, PBT_PRESS = 2'b01,
                             PBT_LONG = 2'b11, PBT_WAITMIN = 2'b10} pbt_state_e;
endpackage

/* File: sim/pbt_bus_model.sv */
`timescale 1ns/10ps
module pbt_bus_model (
   input wire logic       clk_sys,
   input wire logic       dim_send,
   input wire logic [3:0] dim_code,
   input wire logic       move_send,
   input wire logic       move_down,
   input wire logic       slat_send,
   input wire logic       slat_close,
   input wire logic       val_short_send,
   input wire logic       val_long_send,
   input wire logic [3:0] link_move_send,
   input wire logic [3:0] link_slat_send
);
   // every telegram is logged as {kind, value}; actuators only listen, never answer
   logic [7:0] log_q[$];
   always @(posedge clk_sys) begin
      if (dim_send === 1'b1) log_q.push_back({4'h1, dim_code});
      if (move_send === 1'b1) log_q.push_back({7'h10, move_down});
      if (slat_send === 1'b1) log_q.push_back({7'h18, slat_close});
      if (val_short_send === 1'b1) log_q.push_back(8'h40);
      if (val_long_send === 1'b1) log_q.push_back(8'h50);
      if (link_move_send !== 4'h0) log_q.push_back({4'h6, link_move_send});
      if (link_slat_send !== 4'h0) log_q.push_back({4'h7, link_slat_send});
   end
endmodule

/* File: sim/pbt_input_properties.sv */
`timescale 1ns/10ps
module pbt_input_properties #(
   parameter int TICK_CYC = 10
) (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        dim_send,
   input wire logic        move_send,
   input wire logic        move_down,
   input wire logic        slat_send,
   input wire logic        val_short_send,
   input wire logic        val_long_send,
   input wire logic [3:0]  link_move_send,
   input wire logic [3:0]  link_slat_send,
   input wire logic        link_dir
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_apb_ready: assert property (psel && !penable |=> pready)
      else $error("no pready in access phase");
   chk_apb_once: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_bad_addr: assert property (psel && !penable && !pwrite && paddr > 12'h018
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   chk_dim_pulse: assert property (dim_send |=> !dim_send)
      else $error("dim telegram longer than one cycle");
   chk_val_split: assert property (val_short_send |-> !val_long_send)
      else $error("short and long value sent together");
   chk_link_move: assert property (link_move_send != 4'h0
      |-> move_send && $onehot(link_move_send) && link_dir == move_down)
      else $error("linked move differs from bus move");
   chk_link_slat: assert property (link_slat_send != 4'h0
      |-> slat_send && $onehot(link_slat_send))
      else $error("linked slat differs from bus slat");
   chk_reset_quiet: assert property ($rose(rst_n)
      |-> (!dim_send && !move_send && !slat_send) [*3])
      else $error("telegram right after reset");
endmodule
bind pbt_input pbt_input_properties #(.TICK_CYC(TICK_CYC)) chk_i (.*);

/* File: sim/tb.sv */
`timescale 1ns/10ps
`include "pbt_defines.svh"
module tb;
   localparam logic [31:0] NC = 32'h0000_0004;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        contact_in = 1'b0;
   logic        updown_obj_wr = 1'b0;
   logic        updown_obj_val = 1'b0;
   logic [31:0] prdata;
   logic [3:0]  dim_code, link_move_send, link_slat_send;
   logic        pready, pslverr, dim_send, move_send, move_down, slat_send;
   logic        slat_close, val_short_send, val_long_send, link_dir, idle;
   logic [7:0]  exp_q[$];
   int          fails = 0;
   int          num_checks = 0;
   pbt_input #(.TICK_CYC(10)) pbt_input_i (.*);
   pbt_bus_model pbt_bus_model_i (.*);
   initial forever #20 clk_sys = ~clk_sys;
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fails++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      check(r, x);
   endtask
   // the contact-type change itself may look like a press; let it settle and drop it
   task automatic cfg(input logic [31:0] c);
      wr(`PBT_ADDR_CTRL, c);
      idle = c[2];
      contact_in <= c[2];
      repeat (300) @(posedge clk_sys);
      exp_q.delete();
      pbt_bus_model_i.log_q.delete();
   endtask
   task automatic press(input int len);
      contact_in <= ~idle;
      repeat (len + $urandom_range(9)) @(posedge clk_sys);
      contact_in <= idle;
      repeat (80) @(posedge clk_sys);
   endtask
   // value nibble F on a blind telegram means any direction is accepted
   task automatic cmp_log;
      logic [7:0] g, e;
      repeat (40) @(posedge clk_sys);
      check(pbt_bus_model_i.log_q.size(), exp_q.size());
      while (exp_q.size() > 0 && pbt_bus_model_i.log_q.size() > 0) begin
         e = exp_q.pop_front();
         g = pbt_bus_model_i.log_q.pop_front();
         if (e[3:0] == 4'hF && e[7:4] != 4'h1) e[3:0] = g[3:0];
         check(g, e);
      end
      exp_q.delete();
      pbt_bus_model_i.log_q.delete();
   endtask
   initial begin
      repeat (30000) @(posedge clk_sys);
      fails++;
      finish_test;
   end
   initial begin
      logic [31:0] r;
      logic        e, d, c;
      int          m;
      r = $urandom(32'h65d59671);
      idle = 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(`PBT_ADDR_DEB, 32'h0000_0032);
      rd(`PBT_ADDR_LONG, 32'h0000_0258);
      rd(`PBT_ADDR_CYCLE, 32'h0000_0258);
      rd(`PBT_ADDR_SLAT, 32'h0000_01F4);
      rd(`PBT_ADDR_MINSIG, 32'h0000_000A);
      apb(1'b0, 12'h01C, 32'h0000_0000, r, e);
      check(r, 32'h0000_0000);
      check(e, 1'b1);
      wr(`PBT_ADDR_DEB, 32'h0000_0002);
      wr(`PBT_ADDR_LONG, 32'h0000_0014);
      wr(`PBT_ADDR_CYCLE, 32'h0000_000A);
      wr(`PBT_ADDR_SLAT, 32'h0000_0008);
      wr(`PBT_ADDR_MINSIG, 32'h0000_0001);
      rd(`PBT_ADDR_LONG, 32'h0000_0014);
      cfg(32'h0000_0000);
      exp_q = '{8'h19, 8'h18};
      press(60);
      cmp_log;
      cfg(32'h0000_0308);
      press(500);
      m = pbt_bus_model_i.log_q.size();
      repeat (300) @(posedge clk_sys);
      check(pbt_bus_model_i.log_q.size(), m);
      check(m >= 3 && m <= 6, 1'b1);
      foreach (pbt_bus_model_i.log_q[i])
         check(pbt_bus_model_i.log_q[i] inside {8'h1B, 8'h18, 8'h10}, 1'b1);
      cfg(32'h0000_8003);
      exp_q = '{8'h40, 8'h50};
      press(60);
      press(300);
      cmp_log;
      cfg(32'h0000_2041);
      exp_q = '{8'h20, 8'h62, 8'h3F, 8'h72, 8'h21, 8'h62, 8'h3F, 8'h72};
      repeat (4) press(60);
      cmp_log;
      cfg(NC | 32'h0000_0061);
      exp_q = '{8'h2F, 8'h3F};
      press(60);
      cmp_log;
      for (m = 4; m < 8; m++) begin
         d = 1'($urandom_range(1));
         c = 1'($urandom_range(1));
         cfg({20'h0_0000, c, 3'h0, 3'(m), d, 4'h5});
         case (m)
            4: exp_q = '{{7'h18, c}, {7'h10, d}};
            5: exp_q = '{{7'h10, d}, {7'h18, c}};
            6: exp_q = '{{7'h10, d}};
            default: exp_q = '{{7'h18, c}};
         endcase
         press(60);
         if (m == 4) press(300);
         cmp_log;
      end
      cfg(NC | 32'h0000_0001);
      updown_obj_val <= 1'b1;
      updown_obj_wr <= 1'b1;
      @(posedge clk_sys);
      updown_obj_wr <= 1'b0;
      exp_q = '{8'h30};
      press(60);
      cmp_log;
      cfg(NC | 32'h0008_0001);
      exp_q = '{8'h31};
      press(60);
      cmp_log;
      cfg(NC | 32'h0002_0003);
      press(60);
      cmp_log;
      cfg(NC | 32'h0006_0003);
      repeat (250) @(posedge clk_sys);
      check(pbt_bus_model_i.log_q.size() inside {2, 3}, 1'b1);
      check(pbt_bus_model_i.log_q[0], 8'h50);
      cfg(NC | 32'h0001_0003);
      contact_in <= ~idle;
      repeat (600) @(posedge clk_sys);
      check(pbt_bus_model_i.log_q.size(), 0);
      repeat (900) @(posedge clk_sys);
      contact_in <= idle;
      repeat (1200) @(posedge clk_sys);
      exp_q = '{8'h40, 8'h50};
      cmp_log;
      finish_test;
   end
endmodule
